/* pkg/dth_pkg.sv */
// Package for the tone transceiver host steering block.
// Assumes a single 20 MHz system clock domain.
package dth_pkg;
	localparam int unsigned CLK_HZ          = 20000000;
	localparam int unsigned OSC_HZ          = 3579545;
	// Latch settle delay before the delayed steering flag rises
	localparam int unsigned SETTLE_NS       = 500;
	localparam int unsigned SETTLE_CYC      = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// Burst and pause lengths in ms
	localparam int unsigned BURST_MS        = 50;
	localparam int unsigned BURST_CYC       = BURST_MS * (CLK_HZ / 1000);
	// Oscillator ticks per burst or pause; kept in 32 bits by dividing last
	localparam int unsigned BURST_TICKS     = BURST_MS * OSC_HZ / 1000;
	// Control register A fields
	localparam int unsigned CRA_TONE_EN     = 0;
	localparam int unsigned CRA_IRQ_EN      = 2;
	localparam int unsigned CRA_CP_MODE     = 1;
	localparam int unsigned CRA_BURST_EN    = 3;
	// Control register B fields
	localparam int unsigned CRB_SINGLE      = 0;
	localparam int unsigned CRB_COLUMN      = 1;
	localparam int unsigned CRB_SEL_B       = 2;
	// Status bits
	localparam int unsigned ST_IRQ          = 0;
	localparam int unsigned ST_TX_EMPTY     = 1;
	localparam int unsigned ST_RX_FULL      = 2;
	localparam int unsigned ST_DSTEER       = 3;
	localparam logic [3:0]  CRA_RESET       = 4'h0;
	localparam logic [3:0]  CRB_RESET       = 4'h0;
	localparam logic [3:0]  DATA_RESET      = 4'h0;
	typedef enum logic [1:0] {
		SEL_TXD,
		SEL_RXD,
		SEL_CTRL,
		SEL_STAT
	} dth_sel_t;
	typedef enum logic [1:0] {
		GEN_IDLE,
		GEN_BURST,
		GEN_PAUSE
	} dth_gen_t;
endpackage

/* pkg/dth_bus_if.sv */
// Carrier between the host port decoder and the core.
// Assumes all signals sit on clk_sys.
`timescale 1ns/1ps
interface dth_bus_if;
	import dth_pkg::*;
	logic       wrStb;
	logic       rdStb;
	dth_sel_t   sel;
	logic [3:0] wrData;
	modport port (output wrStb, output rdStb, output sel, output wrData);
	modport core (input wrStb, input rdStb, input sel, input wrData);
endinterface

/* logic/dth_sync.sv */
// Two flip-flop synchroniser for pins entering clk_sys.
// Assumes an asynchronous active-high reset.
`timescale 1ns/1ps
module dth_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

/* logic/dth_host_port.sv */
// Host nibble bus decoder: turns the falling phase clock edges into strobes.
// Assumes the host pins already passed the synchroniser.
`timescale 1ns/1ps
module dth_host_port
	import dth_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  rst,
	input  wire logic  chipSelN,
	input  wire logic  readNotWrite,
	input  wire logic  registerSelectBit,
	input  wire logic  phaseClk,
	input  wire logic  [3:0] nibbleIn,
	dth_bus_if.port    bus
);
	logic phase_q;
	wire  sel      = ~chipSelN;
	wire  fall     = phase_q & ~phaseClk;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) phase_q <= 1'b0;
		else phase_q <= phaseClk;
	end
	// Writes are taken at the end of the phase, when host data is stable
	assign bus.wrStb  = sel & fall & ~readNotWrite;
	assign bus.rdStb  = sel & fall & readNotWrite;
	assign bus.wrData = nibbleIn;
	// Select bit low picks the data pair, high picks control and status
	assign bus.sel = registerSelectBit ? (readNotWrite ? SEL_STAT : SEL_CTRL)
	                                   : (readNotWrite ? SEL_RXD : SEL_TXD);
endmodule

/* logic/dth_host_steering.sv */
// Top of the host steering block: host nibble port, steering, tone timing.
// Assumes the analog detector supplies a digit and valid level, and the
// tone synthesiser takes row and column enables from here.
`timescale 1ns/1ps
module dth_host_steering
	import dth_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       chipSelN,
	input  wire logic       readNotWrite,
	input  wire logic       registerSelectBit,
	input  wire logic       phaseClk,
	input  wire logic [3:0] hostNibbleBusIn,
	output logic      [3:0] hostNibbleBusOut,
	output logic            hostNibbleBusOe,
	output logic            interruptToneOutOut,
	output logic            interruptToneOutOe,
	input  wire logic       toneValid,
	input  wire logic [3:0] detectDigit,
	input  wire logic       cpPassband,
	output logic            earlyDetect,
	input  wire logic       steeringIn,
	output logic            guardOut,
	output logic            guardOutOe,
	input  wire logic       oscillatorIn,
	output logic            toneRowEn,
	output logic            toneColEn,
	output logic      [3:0] toneCode,
	output logic            callProgressMode
);
	logic [3:0] pinSync;
	logic [2:0] anaSync;
	logic [3:0] nibSync;
	logic       cs;
	logic       rw;
	logic       rsel;
	logic       ph;
	logic       valid;
	logic       stLvl;
	logic       cpIn;
	logic       osc;

	dth_sync #(.W(4)) uSyncPins (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({chipSelN, readNotWrite, registerSelectBit, phaseClk}),
		.dout    (pinSync)
	);
	dth_sync #(.W(3)) uSyncAna (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({steeringIn, cpPassband, oscillatorIn}),
		.dout    (anaSync)
	);
	dth_sync #(.W(4)) uSyncNib (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (hostNibbleBusIn),
		.dout    (nibSync)
	);
	// Cs reset value of zero would select the chip; sync resets to 0 but
	// strobes also need a phase edge, which cannot occur right at reset.
	assign {cs, rw, rsel, ph} = pinSync;
	assign {stLvl, cpIn, osc} = anaSync;
	assign valid = toneValid;

	dth_bus_if bus ();
	dth_host_port uPort (
		.clk_sys           (clk_sys),
		.rst               (rst),
		.chipSelN          (cs),
		.readNotWrite      (rw),
		.registerSelectBit (rsel),
		.phaseClk          (ph),
		.nibbleIn          (nibSync),
		.bus               (bus)
	);

	logic [3:0] ctrlA_q;
	logic [3:0] ctrlB_q;
	logic       selB_q;
	logic [3:0] txData_q;
	logic [3:0] rxData_q;
	logic       rxFull_q;
	logic       txEmpty_q;
	logic       dsteer_q;
	logic       irqFlag_q;
	logic       stPrev_q;
	logic       armed_q;
	logic [7:0] settle_q;
	logic       settling_q;
	logic [3:0] rdData_q;
	logic       rdHold_q;
	logic       genDone;

	wire cpMode  = ctrlA_q[CRA_CP_MODE];
	wire irqEn   = ctrlA_q[CRA_IRQ_EN];
	wire esValid = valid & ~cpMode;
	wire stRise  = stLvl & ~stPrev_q;
	wire regPair = stRise & armed_q & ~cpMode;
	wire settled = settling_q && (settle_q == 8'(SETTLE_CYC));
	// Strobe aimed at one register of the map
	function automatic logic hits(input logic stb, input dth_sel_t s, input dth_sel_t want);
		return stb && (s == want);
	endfunction
	wire statRd  = hits(bus.rdStb, bus.sel, SEL_STAT);
	wire rxRd    = hits(bus.rdStb, bus.sel, SEL_RXD);
	wire txWrite = hits(bus.wrStb, bus.sel, SEL_TXD);
	wire ctrlWr  = hits(bus.wrStb, bus.sel, SEL_CTRL);
	wire ctrlAWr = ctrlWr & ~selB_q;
	wire ctrlBWr = ctrlWr & selB_q;
	wire [3:0] status = {dsteer_q, rxFull_q, txEmpty_q, irqFlag_q};

	assign earlyDetect = esValid;
	assign guardOut    = esValid;
	// Drive the steering node while steering stands above threshold or a valid pair is seen outside CP mode
	assign guardOutOe  = stLvl | esValid;
	assign callProgressMode = cpMode;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stPrev_q <= 1'b0;
			armed_q  <= 1'b1;
		end else begin
			stPrev_q <= stLvl;
			if (regPair) armed_q <= 1'b0;
			else if (~stLvl) armed_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rxData_q   <= DATA_RESET;
			settling_q <= 1'b0;
			settle_q   <= '0;
		end else begin
			if (regPair) begin
				rxData_q   <= detectDigit;
				settling_q <= 1'b1;
				settle_q   <= '0;
			end else if (settled) begin
				settling_q <= 1'b0;
			end else if (settling_q) begin
				settle_q <= settle_q + 8'h01;
			end
		end
	end

	// Set wins over the read clear on rx full and irq, and over the steering-low clear on delayed steering
	wire  dsteerSet = settled;
	wire  dsteerClr = ~stLvl;
	wire  rxFullClr = rxRd;
	wire  irqSet    = settled | genDone;
	wire  irqClr    = statRd;
	logic dsteer_d;
	logic rxFull_d;
	logic irqFlag_d;
	assign dsteer_d  = dsteerSet | (dsteer_q & ~dsteerClr);
	assign rxFull_d  = dsteerSet | (rxFull_q & ~rxFullClr);
	assign irqFlag_d = irqSet | (irqFlag_q & ~irqClr);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dsteer_q  <= 1'b0;
			rxFull_q  <= 1'b0;
			irqFlag_q <= 1'b0;
		end else begin
			dsteer_q  <= dsteer_d;
			rxFull_q  <= rxFull_d;
			irqFlag_q <= irqFlag_d;
		end
	end

	// Bit3 of a control A write alone steers the next control write to B,
	// since B resets with all of its bits clear and could not open itself
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrlA_q  <= CRA_RESET;
			ctrlB_q  <= CRB_RESET;
			selB_q   <= 1'b0;
			txData_q <= DATA_RESET;
		end else begin
			if (txWrite) txData_q <= bus.wrData;
			if (ctrlAWr) ctrlA_q <= bus.wrData;
			if (ctrlBWr) ctrlB_q <= bus.wrData;
			if (ctrlAWr) selB_q <= bus.wrData[CRA_BURST_EN];
			else if (ctrlBWr) selB_q <= 1'b0;
		end
	end

	// Read data is registered every cycle, not held; the enable lags the selected read phase by one cycle
	wire [3:0] rdNext = (bus.sel == SEL_STAT) ? status : rxData_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdData_q <= 4'h0;
			rdHold_q <= 1'b0;
		end else begin
			rdHold_q <= ~cs & ph & rw;
			rdData_q <= rdNext;
		end
	end
	assign hostNibbleBusOut = rdData_q;
	assign hostNibbleBusOe  = rdHold_q & ~cs & ph;

	// Tone timing ticks from oscillator edges; phase clock plays no part
	logic        oscPrev_q;
	logic [23:0] burst_q;
	logic [23:0] burst_d;
	dth_gen_t    gen_q;
	dth_gen_t    gen_d;
	logic        txEmpty_d;
	wire oscTick   = osc & ~oscPrev_q;
	wire burstMode = ctrlA_q[CRA_BURST_EN];
	wire cntZero   = (burst_q == 24'h000000);
	wire phaseEnd  = oscTick & cntZero;
	assign genDone = (gen_q == GEN_PAUSE) && phaseEnd;

	// Zero is a counted tick too, so the load is one short of the length
	function automatic logic [23:0] burst_reload();
		return 24'(BURST_TICKS - 1);
	endfunction

	always_comb begin
		gen_d     = gen_q;
		burst_d   = burst_q;
		txEmpty_d = txEmpty_q;
		case (gen_q)
			GEN_IDLE: begin
				if (txWrite & burstMode) begin
					gen_d     = GEN_BURST;
					burst_d   = burst_reload();
					txEmpty_d = 1'b0;
				end
			end
			GEN_BURST: begin
				if (phaseEnd) begin
					gen_d   = GEN_PAUSE;
					burst_d = burst_reload();
				end else if (oscTick) begin
					burst_d = burst_q - 24'h000001;
				end
			end
			GEN_PAUSE: begin
				if (phaseEnd) begin
					gen_d     = GEN_IDLE;
					txEmpty_d = 1'b1;
				end else if (oscTick) begin
					burst_d = burst_q - 24'h000001;
				end
			end
			default: gen_d = GEN_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			oscPrev_q <= 1'b0;
			gen_q     <= GEN_IDLE;
			burst_q   <= '0;
			txEmpty_q <= 1'b1;
		end else begin
			oscPrev_q <= osc;
			gen_q     <= gen_d;
			burst_q   <= burst_d;
			txEmpty_q <= txEmpty_d;
		end
	end

	wire toneOn = ctrlA_q[CRA_TONE_EN] & (~burstMode | (gen_q == GEN_BURST));
	wire single = ctrlB_q[CRB_SINGLE];
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			toneRowEn <= 1'b0;
			toneColEn <= 1'b0;
			toneCode  <= 4'h0;
		end else begin
			toneCode  <= txData_q;
			toneRowEn <= toneOn & (~single | ~ctrlB_q[CRB_COLUMN]);
			toneColEn <= toneOn & (~single | ctrlB_q[CRB_COLUMN]);
		end
	end

	// Interrupt pin, when IRQ enabled: pulled low on flag, or follows passband wave in CP mode
	wire  cpWave   = cpMode & irqEn;
	wire  irqLevel = irqEn & (dsteer_q | irqFlag_q);
	logic irqPull_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) irqPull_q <= 1'b0;
		else if (cpWave) irqPull_q <= ~cpIn;
		else irqPull_q <= irqLevel;
	end
	assign interruptToneOutOut = 1'b0;
	assign interruptToneOutOe  = irqPull_q;
endmodule

/* tb/dth_host_steering_props.sv */
// Checker on the host steering top ports.
// Assumes host pins pass a two stage synchroniser before use.
`timescale 1ns/1ps
module dth_host_steering_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic chipSelN,
	input wire logic readNotWrite,
	input wire logic phaseClk,
	input wire logic hostNibbleBusOe,
	input wire logic interruptToneOutOut,
	input wire logic interruptToneOutOe,
	input wire logic toneValid,
	input wire logic earlyDetect,
	input wire logic callProgressMode,
	input wire logic guardOut,
	input wire logic guardOutOe,
	input wire logic steeringIn
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Irq rise outside call progress can come from delayed steering or from the end of a burst pause
	sequence s_irq_rise;
		$rose(interruptToneOutOe) && !callProgressMode;
	endsequence
	sequence s_steered;
		$past(steeringIn, 10) && $past(toneValid, 10);
	endsequence
	AST_OE_CS: assert property (hostNibbleBusOe |-> !$past(chipSelN, 3))
		else $error("bus driven while not selected");
	AST_OE_PHASE: assert property (hostNibbleBusOe |-> $past(phaseClk, 3))
		else $error("bus driven with phase low");
	AST_OE_READ: assert property (hostNibbleBusOe |-> $past(readNotWrite, 3))
		else $error("bus driven during a write");
	AST_IRQ_OD: assert property (interruptToneOutOut == 1'b0)
		else $error("interrupt pin driven high");
	AST_ED_RISE: assert property (toneValid && !callProgressMode |-> earlyDetect)
		else $error("early detect missing");
	AST_ED_FALL: assert property (!toneValid |-> !earlyDetect)
		else $error("early detect held after loss");
	AST_CP_BLOCK: assert property (callProgressMode |-> !earlyDetect)
		else $error("tone pair seen in call progress mode");
	AST_GUARD: assert property (earlyDetect |-> guardOut && guardOutOe)
		else $error("guard not driven with early detect");
	AST_DSTEER_IRQ: assert property (s_irq_rise |-> s_steered)
		else $error("interrupt without registered pair");
endmodule

bind dth_host_steering dth_host_steering_props u_props (
	.clk_sys(clk_sys), .rst(rst), .chipSelN(chipSelN), .readNotWrite(readNotWrite),
	.phaseClk(phaseClk), .hostNibbleBusOe(hostNibbleBusOe),
	.interruptToneOutOut(interruptToneOutOut), .interruptToneOutOe(interruptToneOutOe),
	.toneValid(toneValid), .earlyDetect(earlyDetect), .callProgressMode(callProgressMode),
	.guardOut(guardOut), .guardOutOe(guardOutOe), .steeringIn(steeringIn));

/* tb/dth_host_model.sv */
// Host processor model on the nibble bus.
// Assumes a phase clock high for 200 ns per access that stands still between accesses.
`timescale 1ns/1ps
module dth_host_model (
	input  wire logic       clk_sys,
	output logic            chipSelN,
	output logic            readNotWrite,
	output logic            registerSelectBit,
	output logic            phaseClk,
	output logic      [3:0] hostNibbleBusIn,
	input  wire logic [3:0] hostNibbleBusOut,
	input  wire logic       hostNibbleBusOe,
	output logic            rdValid,
	output logic      [3:0] rdData
);
	initial begin
		chipSelN = 1'b1;
		readNotWrite = 1'b1;
		registerSelectBit = 1'b0;
		phaseClk = 1'b0;
		hostNibbleBusIn = 4'h5;
		rdValid = 1'b0;
		rdData = 4'h0;
	end
	// One full phase cycle per access; cs held past the falling phase
	task automatic access(input logic sel, input logic rd, input logic [3:0] wd,
			input logic cs);
		@(posedge clk_sys);
		#1;
		chipSelN = cs;
		readNotWrite = rd;
		registerSelectBit = sel;
		hostNibbleBusIn = rd ? ~hostNibbleBusIn : wd;
		phaseClk = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		rdData = (hostNibbleBusOe === 1'b1) ? hostNibbleBusOut : 4'hX;
		phaseClk = 1'b0;
		rdValid = rd & ~cs;
		@(posedge clk_sys);
		#1;
		rdValid = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chipSelN = 1'b1;
		hostNibbleBusIn = ~hostNibbleBusIn;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
endmodule

/* tb/dth_host_steering_tb_top.sv */
// Self-checking bench for the host steering block.
// Assumes the host model owns the nibble bus pins.
`timescale 1ns/1ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module dth_host_steering_tb_top;
	import dth_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       chipSelN, readNotWrite, registerSelectBit, phaseClk, rdValid;
	logic [3:0] hostNibbleBusIn, hostNibbleBusOut, rdData, toneCode;
	logic       hostNibbleBusOe, interruptToneOutOut, interruptToneOutOe;
	logic       toneValid = 1'b0;
	logic [3:0] detectDigit = 4'h0;
	logic       cpPassband = 1'b0;
	logic       steeringIn = 1'b0;
	logic       oscillatorIn = 1'b0;
	logic       earlyDetect, guardOut, guardOutOe, toneRowEn, toneColEn, callProgressMode;
	logic [3:0] expQ[$];
	int         errors, testsRun, cycles;
	always #25 clk_sys = ~clk_sys;
	always #140 oscillatorIn = ~oscillatorIn;
	dth_host_model u_host (.clk_sys(clk_sys), .chipSelN(chipSelN), .readNotWrite(readNotWrite),
		.registerSelectBit(registerSelectBit), .phaseClk(phaseClk),
		.hostNibbleBusIn(hostNibbleBusIn), .hostNibbleBusOut(hostNibbleBusOut),
		.hostNibbleBusOe(hostNibbleBusOe), .rdValid(rdValid), .rdData(rdData));
	dth_host_steering u_dut (.clk_sys(clk_sys), .rst(rst), .chipSelN(chipSelN),
		.readNotWrite(readNotWrite), .registerSelectBit(registerSelectBit),
		.phaseClk(phaseClk), .hostNibbleBusIn(hostNibbleBusIn),
		.hostNibbleBusOut(hostNibbleBusOut), .hostNibbleBusOe(hostNibbleBusOe),
		.interruptToneOutOut(interruptToneOutOut), .interruptToneOutOe(interruptToneOutOe),
		.toneValid(toneValid), .detectDigit(detectDigit), .cpPassband(cpPassband),
		.earlyDetect(earlyDetect), .steeringIn(steeringIn), .guardOut(guardOut),
		.guardOutOe(guardOutOe), .oscillatorIn(oscillatorIn), .toneRowEn(toneRowEn),
		.toneColEn(toneColEn), .toneCode(toneCode), .callProgressMode(callProgressMode));
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic rd(input logic sel, input logic [3:0] e);
		expQ.push_back(e);
		u_host.access(sel, 1'b1, 4'h0, 1'b0);
	endtask
	task automatic wr(input logic sel, input logic [3:0] d);
		u_host.access(sel, 1'b0, d, 1'b0);
	endtask
	task automatic steer(input logic [3:0] d);
		detectDigit = d;
		toneValid = 1'b1;
		steeringIn = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
	endtask
	// Reads are judged in order of issue; a stray strobe shows as underflow
	always @(posedge clk_sys) begin
		if (rdValid === 1'b1) begin
			if (expQ.size() == 0) begin
				`CHK(1'b1, 1'b0)
			end else begin
				`CHK(rdData, expQ.pop_front())
			end
		end
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		logic [3:0] d;
		logic       seen0, seen1;
		d = 4'($urandom(32'hBF45));
		repeat (4) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK(hostNibbleBusOe, 1'b0)
		rd(1'b1, 4'h2);
		wr(1'b1, 4'h4);
		d = 4'($urandom_range(15, 1));
		steer(d);
		`CHK(earlyDetect, 1'b1)
		`CHK(guardOutOe, 1'b1)
		`CHK(interruptToneOutOe, 1'b1)
		rd(1'b1, 4'hF);
		rd(1'b0, d);
		toneValid = 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK(earlyDetect, 1'b0)
		steeringIn = 1'b0;
		repeat (20) @(posedge clk_sys);
		#1;
		d = ~d;
		steer(d);
		rd(1'b0, d);
		toneValid = 1'b0;
		steeringIn = 1'b0;
		u_host.access(1'b1, 1'b0, 4'h6, 1'b1);
		`CHK(callProgressMode, 1'b0)
		wr(1'b1, 4'h6);
		`CHK(callProgressMode, 1'b1)
		toneValid = 1'b1;
		seen0 = 1'b0;
		seen1 = 1'b0;
		repeat (6) begin
			cpPassband = ~cpPassband;
			repeat (10) @(posedge clk_sys);
			#1;
			seen0 |= (interruptToneOutOe === 1'b0);
			seen1 |= (interruptToneOutOe === 1'b1);
		end
		`CHK({seen0, seen1}, 2'b11)
		`CHK(earlyDetect, 1'b0)
		toneValid = 1'b0;
		wr(1'b1, 4'h1);
		d = 4'($urandom());
		wr(1'b0, d);
		`CHK(toneCode, d)
		`CHK({toneRowEn, toneColEn}, 2'b11)
		wr(1'b1, 4'h9);
		wr(1'b1, 4'h3);
		wr(1'b1, 4'h1);
		`CHK({toneRowEn, toneColEn}, 2'b01)
		`CHK(interruptToneOutOut, 1'b0)
		repeat (4) @(posedge clk_sys);
		give_verdict();
	end
endmodule
